// ==== rtl/uepcsr_regs.svh ====
// Purpose: Offsets, field positions, reset values and wait counts
// Assumes: Included by the package and by both ends
// Notes:   Definitions only
`ifndef UEPCSR_REGS_SVH
`define UEPCSR_REGS_SVH

// ****************************************
// Endpoint control/status field positions
// ****************************************
`define UEPCSR_TRANSMIT_COMPLETE      0
`define UEPCSR_BANK0       1
`define UEPCSR_SETUP       2
`define UEPCSR_STALLACK    3
`define UEPCSR_TXRDY       4
`define UEPCSR_FHALT       5
`define UEPCSR_BANK1       6
`define UEPCSR_DIR         7
`define UEPCSR_KIND_LSB    8
`define UEPCSR_KIND_MSB    10
`define UEPCSR_TOGGLE      11
`define UEPCSR_ENABLE      15
`define UEPCSR_COUNT_LSB   16
`define UEPCSR_COUNT_MSB   26
`define UEPCSR_DPR_MASK    32'h0000_0052

// ****************************************
// Endpoint kind codes and reset values
// ****************************************
`define UEPCSR_KIND_CTRL     3'h0
`define UEPCSR_KIND_ISO_OUT  3'h1
`define UEPCSR_KIND_ISO_IN   3'h5
`define UEPCSR_KIND_BULK_OUT 3'h2
`define UEPCSR_KIND_BULK_IN  3'h6
`define UEPCSR_KIND_INT_OUT  3'h3
`define UEPCSR_KIND_INT_IN   3'h7
`define UEPCSR_COUNT_RST     11'h000

// ****************************************
// Controller word addresses and commands
// ****************************************
`define UEPCSR_A_CTRL   2'h0
`define UEPCSR_A_DATA   2'h1
`define UEPCSR_A_CMD    2'h2
`define UEPCSR_A_SNAP   2'h3
`define UEPCSR_OP_READ  2'h0
`define UEPCSR_OP_SET   2'h1
`define UEPCSR_OP_CLR   2'h2
`define UEPCSR_OP_RAW   2'h3

// ****************************************
// Wait counts in sys_clk cycles; poll limit in reads
// ****************************************
`define UEPCSR_SETTLE_CYC  4'h2
`define UEPCSR_DPR_CYC     4'h6
`define UEPCSR_POLL_LIMIT  8'h40

`endif

// ==== rtl/uepcsr_pkg.sv ====
// Purpose: Types shared by both ends
// Assumes: uepcsr_regs.svh on the include path
// Notes:   Kind numbers live in the header
`include "uepcsr_regs.svh"
`default_nettype none
package uepcsr_pkg;

    typedef enum logic [2:0] {
        KIND_CTRL     = `UEPCSR_KIND_CTRL,
        KIND_ISO_OUT  = `UEPCSR_KIND_ISO_OUT,
        KIND_ISO_IN   = `UEPCSR_KIND_ISO_IN,
        KIND_BULK_OUT = `UEPCSR_KIND_BULK_OUT,
        KIND_BULK_IN  = `UEPCSR_KIND_BULK_IN,
        KIND_INT_OUT  = `UEPCSR_KIND_INT_OUT,
        KIND_INT_IN   = `UEPCSR_KIND_INT_IN
    } uepcsr_kind_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_RDWAIT = 5'h02,
        ST_VFISS  = 5'h04,
        ST_VFWAIT = 5'h08,
        ST_GUARD  = 5'h10
    } uepcsr_state_t;

endpackage
`default_nettype wire

// ==== rtl/uepcsr_if.sv ====
// Purpose: Register port between controller and endpoint logic
// Assumes: One sys_clk for both ends
// Notes:   Read data valid one cycle after the read strobe
`default_nettype none
interface uepcsr_if;
    logic        csrRd;
    logic        csrWr;
    logic [31:0] csrWdata;
    logic [31:0] csrRdata;
    logic        csrRdValid;

    modport device (
        input  csrRd,
        input  csrWr,
        input  csrWdata,
        output csrRdata,
        output csrRdValid
    );

    modport ctrl (
        output csrRd,
        output csrWr,
        output csrWdata,
        input  csrRdata,
        input  csrRdValid
    );
endinterface
`default_nettype wire

// ==== rtl/uepcsr_flag.sv ====
// Purpose: One sticky flag, set by one party and cleared by the other
// Assumes: Same clock for both events
// Notes:   A set in the clearing cycle keeps the flag
`default_nettype none
module uepcsr_flag (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Events
    input  wire logic setEv,
    input  wire logic clrEv,
    // State
    output logic      flag_r
);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_r <= 1'b0;
        else if (ce)
            flag_r <= setEv | (flag_r & ~clrEv);
    end

endmodule
`default_nettype wire

// ==== rtl/uepcsr_device.sv ====
// Purpose: Endpoint control/status logic facing the USB engine
// Assumes: Engine events are one-cycle pulses on sys_clk
// Notes:   Rules below
// Functional notes
// - Firmware polls bits before next write
// - Else wait one bus plus one peripheral cycle
// - Wait three plus three before endpoint RAM
// - Host IN ack sets transmit_complete; write 0 clears
// - Bank 0 stored sets receive_bank0_full flag
// - Firmware reads count, then releases bank
// - Valid SETUP sets setup_received; write 0 clears
// - OUT refused while setup_received is set
// - Host STALL ack sets stall_acknowledged flag
// - Isochronous: same bit flags CRC error
// - Firmware sets ready; device clears after sending
// - Check ready clear; write 0 cancels
// - force_halt write 1 stalls, 0 resumes
// - Halt meaning per kind; ack via flag
// - Bank 1 flag for ping-pong endpoints
// - Control direction: 0 OUT, 1 IN
// - Firmware sets direction before clearing setup
// - Endpoint kind resets to control 000
// - Control endpoints are always enabled
// - Eleven-bit received byte count, read only
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`include "uepcsr_regs.svh"
`default_nettype none
module uepcsr_device (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Register port
    uepcsr_if.device         csr,
    // Engine events
    input  wire logic        inAcked,
    input  wire logic        stallAcked,
    input  wire logic        outStored,
    input  wire logic        outBank,
    input  wire logic [10:0] outByteCount,
    input  wire logic        setupStored,
    input  wire logic        crcError,
    // Engine controls
    output logic             txReady,
    output logic             sendStall,
    output logic             ctrlDirIn,
    output logic             outRefuse,
    output logic             epEnabled,
    output logic [2:0]       epKind,
    output logic             dataToggle,
    output logic             epIntr
);

    // ****************************************
    // Decode
    // ****************************************
    localparam int NFLAG = 6;

    logic             wr;
    logic [31:0]      wd;
    logic             isCtrl;
    logic             isIso;
    logic             outOk;
    logic [NFLAG-1:0] setV;
    logic [NFLAG-1:0] clrV;
    logic [NFLAG-1:0] flagQ;
    logic             transmit_complete;
    logic             bank0;
    logic             bank1;
    logic             setupFlag;
    logic             stallAck;

    logic             forceHalt_r;
    logic             dir_r;
    uepcsr_pkg::uepcsr_kind_t kind_r;
    logic             enable_r;
    logic             toggle_r;
    logic [10:0]      count_r;
    logic [31:0]      rdata_r;
    logic             rdValid_r;
    logic             intr_r;
    logic             enabledOut_r;
    logic [31:0]      word;

    assign wr     = csr.csrWr;
    assign wd     = csr.csrWdata;
    assign isCtrl = (kind_r == uepcsr_pkg::KIND_CTRL);
    assign isIso  = (kind_r == uepcsr_pkg::KIND_ISO_OUT) || (kind_r == uepcsr_pkg::KIND_ISO_IN);
    assign outOk  = outStored & ~setupFlag;

    // ****************************************
    // Sticky flags
    // ****************************************
    always_comb
    begin
        setV = '0;
        clrV = '0;
        setV[0] = inAcked;
        clrV[0] = wr & ~wd[`UEPCSR_TRANSMIT_COMPLETE];
        setV[1] = outOk & ~outBank;
        clrV[1] = wr & ~wd[`UEPCSR_BANK0];
        setV[2] = setupStored;
        clrV[2] = wr & ~wd[`UEPCSR_SETUP];
        setV[3] = (stallAcked & ~isIso) | (crcError & isIso);
        clrV[3] = wr & ~wd[`UEPCSR_STALLACK];
        setV[4] = wr & wd[`UEPCSR_TXRDY];
        clrV[4] = inAcked | (wr & ~wd[`UEPCSR_TXRDY]);
        setV[5] = outOk & outBank;
        clrV[5] = wr & ~wd[`UEPCSR_BANK1];
    end

    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++)
        begin : g_flag
            uepcsr_flag u_flag (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .ce      (ce),
                .setEv   (setV[gi]),
                .clrEv   (clrV[gi]),
                .flag_r  (flagQ[gi])
            );
        end
    endgenerate

    assign transmit_complete    = flagQ[0];
    assign bank0     = flagQ[1];
    assign setupFlag = flagQ[2];
    assign stallAck  = flagQ[3];
    assign txReady   = flagQ[4];
    assign bank1     = flagQ[5];
    assign outRefuse = setupFlag;

    // ****************************************
    // Firmware-owned settings
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            forceHalt_r <= 1'b0;
        else if (ce && wr)
            forceHalt_r <= wd[`UEPCSR_FHALT];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            dir_r <= 1'b0;
        else if (ce && wr)
            dir_r <= wd[`UEPCSR_DIR];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            kind_r <= uepcsr_pkg::KIND_CTRL;
        else if (ce && wr)
            kind_r <= uepcsr_pkg::uepcsr_kind_t'(wd[`UEPCSR_KIND_MSB:`UEPCSR_KIND_LSB]);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            enable_r <= 1'b0;
        else if (ce && wr)
            enable_r <= wd[`UEPCSR_ENABLE];
    end

    // ****************************************
    // Packet bookkeeping
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            toggle_r <= 1'b0;
        else if (ce)
        begin
            if (setupStored)
                toggle_r <= 1'b1;
            else if (inAcked || outOk)
                toggle_r <= ~toggle_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= `UEPCSR_COUNT_RST;
        else if (ce && (outOk || setupStored))
            count_r <= outByteCount;
    end

    // ****************************************
    // Read port and engine outputs
    // ****************************************
    always_comb
    begin
        word = '0;
        word[`UEPCSR_TRANSMIT_COMPLETE]   = transmit_complete;
        word[`UEPCSR_BANK0]    = bank0;
        word[`UEPCSR_SETUP]    = setupFlag;
        word[`UEPCSR_STALLACK] = stallAck;
        word[`UEPCSR_TXRDY]    = txReady;
        word[`UEPCSR_FHALT]    = forceHalt_r;
        word[`UEPCSR_BANK1]    = bank1;
        word[`UEPCSR_DIR]      = dir_r;
        word[`UEPCSR_KIND_MSB:`UEPCSR_KIND_LSB]   = kind_r;
        word[`UEPCSR_TOGGLE]   = toggle_r;
        word[`UEPCSR_ENABLE]   = isCtrl | enable_r;
        word[`UEPCSR_COUNT_MSB:`UEPCSR_COUNT_LSB] = count_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r   <= 32'h0000_0000;
            rdValid_r <= 1'b0;
        end
        else if (ce)
        begin
            rdValid_r <= csr.csrRd;
            if (csr.csrRd)
                rdata_r <= word;
        end
    end

    // Interrupt stays up while any event flag is set
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            intr_r       <= 1'b0;
            enabledOut_r <= 1'b1;
        end
        else if (ce)
        begin
            intr_r       <= transmit_complete | bank0 | bank1 | setupFlag | stallAck;
            if (wr)
                enabledOut_r <= (wd[`UEPCSR_KIND_MSB:`UEPCSR_KIND_LSB] == `UEPCSR_KIND_CTRL) | wd[`UEPCSR_ENABLE];
        end
    end

    assign csr.csrRdata   = rdata_r;
    assign csr.csrRdValid = rdValid_r;
    assign sendStall      = forceHalt_r;
    assign ctrlDirIn      = dir_r;
    assign epKind         = kind_r;
    assign dataToggle     = toggle_r;
    assign epIntr         = intr_r;
    assign epEnabled      = enabledOut_r;

endmodule
`default_nettype wire

// ==== rtl/uepcsr_ctrl.sv ====
// Purpose: Firmware-side agent driving the endpoint register port
// Assumes: Avalon-MM slave with waitrequest, word addresses
// Notes:   Does read-modify-write, polling and guard waits
`include "uepcsr_regs.svh"
`default_nettype none
module uepcsr_ctrl (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Avalon-MM slave
    input  wire logic [1:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Endpoint register port
    uepcsr_if.ctrl           csr,
    // Status
    output logic             busy
);

    // ****************************************
    // Bus slave
    // ****************************************
    uepcsr_pkg::uepcsr_state_t state_r;
    logic        waitReq_r;
    logic [31:0] rdata_r;
    logic        pollMode_r;
    logic [31:0] data_r;
    logic [31:0] snap_r;
    logic        timedOut_r;
    logic [1:0]  op_r;
    logic [3:0]  guard_r;
    logic [7:0]  polls_r;
    logic        rd_r;
    logic        wr_r;
    logic [31:0] wdata_r;
    logic        busy_r;
    logic        stallCmd;
    logic        acc;
    logic        cmdGo;
    logic [3:0]  guardLen;
    logic [31:0] maskRd;
    logic        polledOk;

    assign stallCmd = avs_write && (avs_address == `UEPCSR_A_CMD) && busy_r;
    assign acc      = (avs_read || avs_write) && !waitReq_r;
    assign cmdGo    = acc && avs_write && (avs_address == `UEPCSR_A_CMD);
    // Touching bank or ready flags needs the longer guard before RAM access
    assign guardLen = ((data_r & `UEPCSR_DPR_MASK) != 32'h0000_0000) ? `UEPCSR_DPR_CYC : `UEPCSR_SETTLE_CYC;
    assign maskRd   = csr.csrRdata & data_r;
    assign polledOk = (op_r == `UEPCSR_OP_SET) ? (maskRd == data_r) : (maskRd != data_r);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitReq_r <= 1'b1;
            rdata_r   <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (!waitReq_r)
                waitReq_r <= 1'b1;
            else if ((avs_read || avs_write) && !stallCmd)
            begin
                waitReq_r <= 1'b0;
                case (avs_address)
                    `UEPCSR_A_CTRL: rdata_r <= {31'h0000_0000, pollMode_r};
                    `UEPCSR_A_DATA: rdata_r <= data_r;
                    `UEPCSR_A_CMD:  rdata_r <= {30'h0000_0000, timedOut_r, busy_r};
                    default:        rdata_r <= snap_r;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pollMode_r <= 1'b1;
            data_r     <= 32'h0000_0000;
        end
        else if (ce && acc && avs_write)
        begin
            if (avs_address == `UEPCSR_A_CTRL)
                pollMode_r <= avs_writedata[0];
            if (avs_address == `UEPCSR_A_DATA)
                data_r <= avs_writedata;
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= uepcsr_pkg::ST_IDLE;
            op_r       <= `UEPCSR_OP_READ;
            snap_r     <= 32'h0000_0000;
            timedOut_r <= 1'b0;
            guard_r    <= 4'h0;
            polls_r    <= 8'h00;
            rd_r       <= 1'b0;
            wr_r       <= 1'b0;
            wdata_r    <= 32'h0000_0000;
        end
        else if (ce)
        begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            case (state_r)
                uepcsr_pkg::ST_IDLE:
                    if (cmdGo)
                    begin
                        op_r       <= avs_writedata[1:0];
                        timedOut_r <= 1'b0;
                        polls_r    <= 8'h00;
                        if (avs_writedata[1:0] == `UEPCSR_OP_RAW)
                        begin
                            wr_r    <= 1'b1;
                            wdata_r <= data_r;
                            guard_r <= guardLen;
                            state_r <= uepcsr_pkg::ST_GUARD;
                        end
                        else
                        begin
                            rd_r    <= 1'b1;
                            state_r <= uepcsr_pkg::ST_RDWAIT;
                        end
                    end
                uepcsr_pkg::ST_RDWAIT:
                    if (csr.csrRdValid)
                    begin
                        snap_r <= csr.csrRdata;
                        if (op_r == `UEPCSR_OP_READ)
                            state_r <= uepcsr_pkg::ST_IDLE;
                        else
                        begin
                            wr_r <= 1'b1;
                            // Clearing writes 0 to the chosen flags; a 0 to the ready flag also cancels a pending send
                            wdata_r <= (op_r == `UEPCSR_OP_SET) ? (csr.csrRdata | data_r)
                                                                : (csr.csrRdata & ~data_r);
                            guard_r <= guardLen;
                            state_r <= pollMode_r ? uepcsr_pkg::ST_VFISS : uepcsr_pkg::ST_GUARD;
                        end
                    end
                uepcsr_pkg::ST_VFISS:
                begin
                    rd_r    <= 1'b1;
                    polls_r <= polls_r + 8'h01;
                    state_r <= uepcsr_pkg::ST_VFWAIT;
                end
                uepcsr_pkg::ST_VFWAIT:
                    if (csr.csrRdValid)
                    begin
                        snap_r <= csr.csrRdata;
                        if (polledOk)
                            state_r <= uepcsr_pkg::ST_GUARD;
                        else if (polls_r == `UEPCSR_POLL_LIMIT)
                        begin
                            timedOut_r <= 1'b1;
                            state_r    <= uepcsr_pkg::ST_IDLE;
                        end
                        else
                            state_r <= uepcsr_pkg::ST_VFISS;
                    end
                uepcsr_pkg::ST_GUARD:
                    if (guard_r <= 4'h1)
                        state_r <= uepcsr_pkg::ST_IDLE;
                    else
                        guard_r <= guard_r - 4'h1;
                default:
                    state_r <= uepcsr_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_r <= 1'b0;
        else if (ce)
            busy_r <= cmdGo || (state_r != uepcsr_pkg::ST_IDLE && !(state_r == uepcsr_pkg::ST_GUARD && guard_r <= 4'h1)
                      && !(state_r == uepcsr_pkg::ST_RDWAIT && csr.csrRdValid && op_r == `UEPCSR_OP_READ)
                      && !(state_r == uepcsr_pkg::ST_VFWAIT && csr.csrRdValid && !polledOk
                           && polls_r == `UEPCSR_POLL_LIMIT));
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = waitReq_r;
    assign csr.csrRd       = rd_r;
    assign csr.csrWr       = wr_r;
    assign csr.csrWdata    = wdata_r;
    assign busy            = busy_r;

endmodule
`default_nettype wire

// ==== testbench/uepcsr_properties.sv ====
// Purpose: Port relations between the two ends
// Assumes: One clock domain
// Notes:   Instantiated beside the interface
`default_nettype none
module uepcsr_properties (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Endpoint port
    input  wire logic        csrRd,
    input  wire logic        csrWr,
    input  wire logic [31:0] csrWdata,
    input  wire logic [31:0] csrRdata,
    input  wire logic        csrRdValid,
    // Engine controls
    input  wire logic        txReady,
    input  wire logic        sendStall,
    input  wire logic        outRefuse,
    input  wire logic        epEnabled,
    input  wire logic [2:0]  epKind,
    input  wire logic        epIntr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_RD_ANSWER: assert property (csrRd |=> csrRdValid)
        else $error("read strobe not answered");
    AST_NO_STRAY: assert property (csrRdValid |-> $past(csrRd))
        else $error("read valid without strobe");
    AST_KIND_RESET: assert property ($rose(rst_n) |-> epKind == 3'h0 && epEnabled)
        else $error("kind not control after reset");
    AST_CTRL_ON: assert property (epKind == 3'h0 |-> epEnabled)
        else $error("control endpoint disabled");
    AST_HALT_WR: assert property (csrWr |=> sendStall == $past(csrWdata[5]))
        else $error("halt does not follow write");
    AST_TXRDY_WR: assert property (csrWr && csrWdata[4] |=> txReady)
        else $error("ready not set by write");
    AST_SETUP_INTR: assert property (outRefuse |=> epIntr)
        else $error("setup flag without interrupt");
    AST_TX_READ: assert property (csrRdValid |-> csrRdata[4] == $past(txReady))
        else $error("ready read mismatch");
    AST_SETUP_READ: assert property (csrRdValid |-> csrRdata[2] == $past(outRefuse))
        else $error("setup read mismatch");
    AST_KIND_READ: assert property (csrRdValid |-> csrRdata[10:8] == $past(epKind))
        else $error("kind read mismatch");
endmodule
`default_nettype wire

// ==== testbench/usb_device_endpoint_csr_tb_top.sv ====
// Purpose: Drives Avalon and engine events
// Assumes: Controller polls and guards each set and clear command
// Notes:   Endpoint word is read back through the snapshot
`include "uepcsr_regs.svh"
`default_nettype none
module usb_device_endpoint_csr_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk;
    logic        rst_n;
    logic [1:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        busy;
    logic [4:0]  evs;
    logic        outBank;
    logic [10:0] outByteCount;
    logic        txReady;
    logic        sendStall;
    logic        ctrlDirIn;
    logic        outRefuse;
    logic        epEnabled;
    logic [2:0]  epKind;
    logic        epIntr;
    logic [31:0] w;
    logic [2:0]  codes [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int          errors;
    int          tests_run;
    uepcsr_if bus ();
    uepcsr_ctrl u_uepcsr_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'h1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .csr(bus), .busy(busy));
    uepcsr_device u_uepcsr_device (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'h1), .csr(bus),
        .inAcked(evs[1]), .stallAcked(evs[2]), .outStored(evs[0]), .outBank(outBank),
        .outByteCount(outByteCount), .setupStored(evs[3]), .crcError(evs[4]), .txReady(txReady),
        .sendStall(sendStall), .ctrlDirIn(ctrlDirIn), .outRefuse(outRefuse), .epEnabled(epEnabled),
        .epKind(epKind), .dataToggle(), .epIntr(epIntr));
    uepcsr_properties u_uepcsr_properties (.sys_clk(sys_clk), .rst_n(rst_n), .csrRd(bus.csrRd),
        .csrWr(bus.csrWr), .csrWdata(bus.csrWdata), .csrRdata(bus.csrRdata), .csrRdValid(bus.csrRdValid),
        .txReady(txReady), .sendStall(sendStall), .outRefuse(outRefuse), .epEnabled(epEnabled),
        .epKind(epKind), .epIntr(epIntr));

    task end_sim;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task tmo;
        errors++;
        end_sim();
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // One Avalon access; read data land in w
    task av(input logic [1:0] a, input logic wr, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        for (n = 0; n < 99 && avs_waitrequest !== 1'h0; n++)
            @(posedge sys_clk);
        if (n >= 99)
            tmo();
        w = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task cmd(input logic [1:0] op, input logic [31:0] m);
        int n;
        av(2'h1, 1'h1, m);
        av(2'h2, 1'h1, {30'h0000_0000, op});
        for (n = 0; n < 200; n++)
        begin
            av(2'h2, 1'h0, 32'h0000_0000);
            if (w[0] === 1'h0)
                break;
        end
        if (n >= 200)
            tmo();
    endtask
    task rd;
        cmd(`UEPCSR_OP_READ, 32'h0000_0000);
        av(2'h3, 1'h0, 32'h0000_0000);
    endtask
    task ev(input logic [4:0] k, input logic b, input logic [10:0] c);
        @(posedge sys_clk);
        evs <= k;
        outBank <= b;
        outByteCount <= c;
        @(posedge sys_clk);
        evs <= 5'h00;
    endtask

    task s_reset;
        av(2'h0, 1'h0, 32'h0000_0000);
        chk("poll mode", 32'h0000_0001, w);
        rd();
        chk("reset word", 32'h0000_8000, w);
    endtask
    task s_tx;
        cmd(`UEPCSR_OP_SET, 32'h0000_0010);
        @(negedge sys_clk);
        chk("tx ready", 1, txReady);
        ev(5'h02, 1'h0, 11'h000);
        rd();
        chk("tx done", 32'h0000_0801, w & 32'h0000_0811);
        chk("tx intr", 1, epIntr);
        cmd(`UEPCSR_OP_CLR, 32'h0000_0001);
        rd();
        chk("tx cleared", 0, w & 32'h0000_0011);
        cmd(`UEPCSR_OP_SET, 32'h0000_0001);
        chk("set one refused", 1, w[1]);
        cmd(`UEPCSR_OP_SET, 32'h0000_0010);
        cmd(`UEPCSR_OP_CLR, 32'h0000_0010);
        @(negedge sys_clk);
        chk("tx cancel", 0, txReady);
    endtask
    task s_out;
        ev(5'h01, 1'h0, 11'h040);
        rd();
        chk("bank0", 32'h0040_0002, w & 32'h07ff_0042);
        ev(5'h01, 1'h1, 11'h7ff);
        rd();
        chk("bank1", 32'h07ff_0042, w & 32'h07ff_0042);
        cmd(`UEPCSR_OP_CLR, 32'h0000_0042);
        rd();
        chk("released", 32'h07ff_0000, w & 32'h07ff_0042);
        cmd(`UEPCSR_OP_RAW, 32'h0000_0042);
        rd();
        chk("write one", 32'h07ff_0000, w & 32'h07ff_0042);
    endtask
    task s_setup;
        ev(5'h08, 1'h0, 11'h008);
        @(negedge sys_clk);
        chk("refuse", 1, outRefuse);
        ev(5'h01, 1'h0, 11'h010);
        rd();
        chk("setup", 32'h0008_0004, w & 32'h07ff_0006);
        cmd(`UEPCSR_OP_SET, 32'h0000_0080);
        chk("dir in", 1, ctrlDirIn);
        cmd(`UEPCSR_OP_CLR, 32'h0000_0004);
        chk("refuse off", 0, outRefuse);
        cmd(`UEPCSR_OP_CLR, 32'h0000_0080);
        chk("dir out", 0, ctrlDirIn);
        chk("intr off", 0, epIntr);
    endtask
    task s_halt;
        cmd(`UEPCSR_OP_SET, 32'h0000_0020);
        chk("halt", 1, sendStall);
        ev(5'h04, 1'h0, 11'h000);
        rd();
        chk("halt ack", 32'h0000_0028, w & 32'h0000_0028);
        cmd(`UEPCSR_OP_CLR, 32'h0000_0028);
        rd();
        chk("halt off", 0, w & 32'h0000_0028);
    endtask
    task s_kind;
        foreach (codes[i])
        begin
            cmd(`UEPCSR_OP_RAW, {21'h00_0000, 3'h0, codes[i], 8'h00});
            rd();
            chk("kind", {5'h00, codes[i]}, w[15:8] & 8'h87);
        end
        cmd(`UEPCSR_OP_RAW, 32'h0000_8100);
        ev(5'h10, 1'h0, 11'h000);
        rd();
        chk("iso error", 1, w[3]);
        cmd(`UEPCSR_OP_CLR, 32'h0000_0008);
        rd();
        chk("iso clear", 0, w[3]);
        cmd(`UEPCSR_OP_RAW, 32'h0000_0000);
        rd();
        chk("ctrl enable", 32'h0000_8000, w & 32'h0000_8700);
    endtask

    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        rst_n = 1'h0;
        {avs_address, avs_read, avs_write, avs_writedata} = 36'h0_0000_0000;
        {evs, outBank, outByteCount} = 17'h0_0000;
        errors = 0;
        tests_run = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        s_reset();
        s_tx();
        s_out();
        s_setup();
        s_halt();
        s_kind();
        end_sim();
    end
endmodule
`default_nettype wire
